// ### design/vcwb_cache.sv
// direct-mapped write-through virtual cache with posted writes
`timescale 1ns/1ps
`include "vcwb_defines.svh"
module vcwb_cache (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// processor request
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [31:0] cpu_addr,
	input wire logic [2:0] cpu_fc,
	input wire logic [31:0] cpu_wdata,
	// processor answer
	output logic cpu_ack,
	output logic [31:0] cpu_rdata,
	// read fill from the paged translation unit
	output logic fill_req,
	output logic [31:0] fill_addr,
	output logic [2:0] fill_fc,
	input wire logic fill_ack,
	input wire logic [31:0] fill_data,
	// posted writes to the paged translation unit
	output logic xlt_wr_valid,
	output logic [31:0] xlt_wr_addr,
	output logic [2:0] xlt_wr_fc,
	output logic [31:0] xlt_wr_data,
	input wire logic xlt_wr_ready
);
	// all control state in one struct
	// the drain stage fields sit here so the pins come from flops
	typedef struct packed {
		vcwb_pkg::vcwb_state_type st;
		logic ack;
		logic [31:0] rdata;
		logic freq;
		logic [31:0] faddr;
		logic [2:0] ffc;
		logic wv;
		vcwb_pkg::vcwb_wr_type went;
	} vcwb_state_struct_type;

	vcwb_state_struct_type s_q, s_d;
	// cache arrays; tag covers all upper bits so nothing aliases
	// 2048 words of 32 bits make the whole 8 KB; one word per entry
	// valid bits live in flops so a reset clears them in one cycle
	logic [`VCWB_DATA_W-1:0] data_q [`VCWB_ENTRIES];
	logic [`VCWB_TAG_W-1:0] tag_q [`VCWB_ENTRIES];
	logic [`VCWB_ENTRIES-1:0] valid_q;
	logic [`VCWB_IDX_W-1:0] idx;
	logic [`VCWB_TAG_W-1:0] tag;
	logic hit, buf_ready, pop_valid, pop_take;
	// write offered to the buffer this cycle
	logic push_wr;
	// entry index of the outstanding miss, taken from the held address
	logic [`VCWB_IDX_W-1:0] fidx;
	logic wr_en, fill_en;
	logic [31:0] wr_data;
	vcwb_pkg::vcwb_wr_type push_e, pop_e;

	// address split: index picks the entry, the bits above it are compared
	// whole, so two addresses that differ in any upper bit always
	// miss against each other; the function code is carried along
	// but takes no part in the match, so one entry serves all codes
	assign idx = cpu_addr[`VCWB_IDX_MSB:`VCWB_IDX_LSB];
	assign tag = cpu_addr[31:`VCWB_TAG_LSB];
	assign hit = valid_q[idx] && (tag_q[idx] == tag);
	assign push_e = '{addr: cpu_addr, fc: cpu_fc, data: cpu_wdata};
	// a write is offered every idle cycle until the buffer takes it, never while ack stands
	assign push_wr = cpu_req && cpu_we && !s_q.ack &&
		(s_q.st == vcwb_pkg::VCWB_IDLE);
	// the fill writes where the miss was seen, not where the bus is now
	assign fidx = s_q.faddr[`VCWB_IDX_MSB:`VCWB_IDX_LSB];

	// output stage register holds head until translation side takes it
	// a new head is pulled when the stage is empty or is being taken,
	// so back-to-back drains lose no cycle; the stage adds one entry
	// of slack on top of the buffer depth
	assign pop_take = pop_valid && (!s_q.wv || xlt_wr_ready);

	// buffer sits between processor side and translation side
	// the processor waits on the drain only through a full buffer, which
	// holds a write back, and then only that write
	vcwb_write_buffer u_wbuf (
		.clk(clk),
		.nrst(nrst),
		.push_valid(push_wr),
		.push_entry(push_e),
		.push_ready(buf_ready),
		.pop_valid(pop_valid),
		.pop_entry(pop_e),
		.pop_ready(pop_take)
	);

	// sequencer: one cycle for hits and writes, fill wait for misses
	// a request is taken at the edge where it is seen in idle and the
	// ack goes out on the next cycle; a request still high while ack
	// stands is the one just served and is ignored, which is why the
	// processor must drop it right after the ack
	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		wr_en = 1'b0;
		fill_en = 1'b0;
		wr_data = cpu_wdata;
		// drain side runs independently of the processor side
		// clearing and loading the stage in one cycle: the load wins,
		// so a taken head is replaced by the next one without a gap
		if (s_q.wv && xlt_wr_ready) begin
			s_d.wv = 1'b0;
		end
		if (pop_take) begin
			s_d.wv = 1'b1;
			s_d.went = pop_e;
		end
		unique case (s_q.st)
			vcwb_pkg::VCWB_IDLE: begin
				if (cpu_req && !s_q.ack) begin
					if (cpu_we) begin
						// full buffer stalls writes only
						if (buf_ready) begin
							// write through, allocate on miss
							// the entry is overwritten even on a hit: the
							// written word is the newest copy
							wr_en = 1'b1;
							s_d.ack = 1'b1;
						end
					end else if (hit) begin
						// read hit does not wait on drains
						s_d.rdata = data_q[idx];
						s_d.ack = 1'b1;
					end else begin
						// miss: hold address and code for the far side
						s_d.freq = 1'b1;
						s_d.faddr = cpu_addr;
						s_d.ffc = cpu_fc;
						s_d.st = vcwb_pkg::VCWB_FILL;
					end
				end
			end
			vcwb_pkg::VCWB_FILL: begin
				if (fill_ack) begin
					// fill word goes to the entry and the processor
					fill_en = 1'b1;
					wr_data = fill_data;
					s_d.freq = 1'b0;
					s_d.rdata = fill_data;
					s_d.ack = 1'b1;
					s_d.st = vcwb_pkg::VCWB_DONE;
				end
			end
			vcwb_pkg::VCWB_DONE: begin
				// one idle cycle lets the processor drop its request
				s_d.st = vcwb_pkg::VCWB_IDLE;
			end
			// the unused state code falls back to idle
			default: begin
				s_d.st = vcwb_pkg::VCWB_IDLE;
			end
		endcase
	end

	// control state register
	// reset is synchronous; all outputs are low while it is held
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// valid bits cleared at reset, set on allocation or fill
	always_ff @(posedge clk) begin
		if (!nrst) begin
			valid_q <= '0;
		end else if (wr_en) begin
			// write allocates the entry it indexes
			valid_q[idx] <= 1'b1;
		end else if (fill_en) begin
			// miss fill validates the entry of the held address
			valid_q[fidx] <= 1'b1;
		end
	end

	// tag and data arrays; miss fill uses the address held in faddr
	// no reset on the arrays: the valid bits alone guard them, and
	// leaving them unreset keeps them mappable onto plain memory;
	// a write and a fill never fall in one cycle, since writes are
	// taken only in idle
	always_ff @(posedge clk) begin
		if (wr_en) begin
			data_q[idx] <= wr_data;
			tag_q[idx] <= tag;
		end else if (fill_en) begin
			data_q[fidx] <= wr_data;
			tag_q[fidx] <= s_q.faddr[31:`VCWB_TAG_LSB];
		end
	end

	// outputs straight from flip-flops
	// every port below is a field of the registered state, so nothing
	// combinational reaches the pins of the block
	assign cpu_ack = s_q.ack;
	assign cpu_rdata = s_q.rdata;
	assign fill_req = s_q.freq;
	assign fill_addr = s_q.faddr;
	assign fill_fc = s_q.ffc;
	assign xlt_wr_valid = s_q.wv;
	assign xlt_wr_addr = s_q.went.addr;
	assign xlt_wr_fc = s_q.went.fc;
	assign xlt_wr_data = s_q.went.data;
endmodule // vcwb_cache

// ### design/vcwb_defines.svh
// constants for the virtual cache and write buffer
`ifndef VCWB_DEFINES_SVH
`define VCWB_DEFINES_SVH
`define VCWB_ADDR_W 32
`define VCWB_FC_W 3
`define VCWB_DATA_W 32
`define VCWB_ENTRIES 2048
`define VCWB_IDX_W 11
`define VCWB_IDX_LSB 2
`define VCWB_IDX_MSB 12
`define VCWB_TAG_LSB 13
`define VCWB_TAG_W 19
`define VCWB_WB_DEPTH 4
`define VCWB_WB_PTR_W 2
`endif

// ### design/vcwb_pkg.sv
// types shared by the virtual cache and write buffer
package vcwb_pkg;
	// one posted write: virtual address, function code, data
	typedef struct packed {
		logic [31:0] addr;
		logic [2:0] fc;
		logic [31:0] data;
	} vcwb_wr_type;
	// processor-side sequencer states
	typedef enum logic [1:0] {
		VCWB_IDLE,
		VCWB_FILL,
		VCWB_DONE
	} vcwb_state_type;
endpackage

// ### design/vcwb_write_buffer.sv
// posted write buffer between processor side and translation side
`timescale 1ns/1ps
`include "vcwb_defines.svh"
module vcwb_write_buffer (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// processor-side push
	input wire logic push_valid,
	input wire vcwb_pkg::vcwb_wr_type push_entry,
	output logic push_ready,
	// translation-side drain
	output logic pop_valid,
	output vcwb_pkg::vcwb_wr_type pop_entry,
	input wire logic pop_ready
);
	// pointer state in one struct
	typedef struct packed {
		logic [`VCWB_WB_PTR_W:0] wp;
		logic [`VCWB_WB_PTR_W:0] rp;
	} vcwb_wb_state_type;

	vcwb_wb_state_type s_q, s_d;
	// entry storage kept outside the struct to keep it small
	vcwb_pkg::vcwb_wr_type mem_q [`VCWB_WB_DEPTH];
	logic full, empty, do_push, do_pop;

	// full when pointers differ only in the wrap bit
	assign full = (s_q.wp[`VCWB_WB_PTR_W] != s_q.rp[`VCWB_WB_PTR_W]) &&
		(s_q.wp[`VCWB_WB_PTR_W-1:0] == s_q.rp[`VCWB_WB_PTR_W-1:0]);
	assign empty = (s_q.wp == s_q.rp);
	assign push_ready = !full;
	assign pop_valid = !empty;
	assign pop_entry = mem_q[s_q.rp[`VCWB_WB_PTR_W-1:0]];
	assign do_push = push_valid && !full;
	assign do_pop = pop_ready && !empty;

	// pointer update
	always_comb begin
		s_d = s_q;
		if (do_push) begin
			s_d.wp = s_q.wp + 1'b1;
		end
		if (do_pop) begin
			s_d.rp = s_q.rp + 1'b1;
		end
	end

	// register pointers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// write storage; no reset needed, guarded by pointers
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem_q[s_q.wp[`VCWB_WB_PTR_W-1:0]] <= push_entry;
		end
	end
endmodule // vcwb_write_buffer

// ### bench/vcwb_props.sv
// port assertions for the virtual cache
`timescale 1ns/1ps
module vcwb_props (
	// clock, reset and single-bit lines
	input wire logic clk, nrst, cpu_req, cpu_we, cpu_ack,
	input wire logic fill_req, fill_ack, xlt_wr_valid, xlt_wr_ready,
	// buses
	input wire logic [31:0] cpu_addr, cpu_wdata, cpu_rdata, fill_addr,
	input wire logic [31:0] fill_data, xlt_wr_addr, xlt_wr_data,
	input wire logic [2:0] cpu_fc, fill_fc, xlt_wr_fc
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_ack_pulse: assert property (cpu_ack |=> !cpu_ack)
		else $error("ack too long");
	a_ack_cause: assert property (cpu_ack |-> $past(cpu_req))
		else $error("ack without request");
	a_wr_post: assert property (cpu_ack && cpu_we |=> xlt_wr_valid)
		else $error("write not posted");
	a_wr_data: assert property (cpu_ack && cpu_we && !xlt_wr_valid |=>
		xlt_wr_data == $past(cpu_wdata) && xlt_wr_addr == $past(cpu_addr))
		else $error("posted write wrong");
	a_fill_addr: assert property (fill_req |->
		fill_addr == cpu_addr && fill_fc == cpu_fc)
		else $error("fill address wrong");
	a_fill_read: assert property (fill_req |-> !cpu_we)
		else $error("fill on write");
	a_fill_hold: assert property (fill_req && !fill_ack |=>
		fill_req && $stable(fill_addr)) else $error("fill dropped");
	a_miss_data: assert property (fill_req && fill_ack |=>
		cpu_ack && cpu_rdata == $past(fill_data)) else $error("miss data");
	a_drain_hold: assert property (xlt_wr_valid && !xlt_wr_ready |=>
		xlt_wr_valid && $stable(xlt_wr_data)) else $error("drain dropped");
	c_miss: cover property (fill_req && fill_ack);
	c_write: cover property (cpu_ack && cpu_we);
	c_stall: cover property (xlt_wr_valid && !xlt_wr_ready);
endmodule // vcwb_props
bind vcwb_cache vcwb_props chk_u (.clk, .nrst, .cpu_req, .cpu_we, .cpu_ack,
	.fill_req, .fill_ack, .xlt_wr_valid, .xlt_wr_ready, .cpu_addr, .cpu_wdata,
	.cpu_rdata, .fill_addr, .fill_data, .xlt_wr_addr, .xlt_wr_data, .cpu_fc,
	.fill_fc, .xlt_wr_fc);

// ### bench/vcwb_mem_model.sv
// memory-side partner: answers fills, drains posted writes
`timescale 1ns/1ps
module vcwb_mem_model (
	// clock, reset, stall control
	input wire logic clk, nrst, hold,
	// fill and drain
	input wire logic fill_req, xlt_wr_valid,
	input wire logic [31:0] fill_addr, xlt_wr_addr, xlt_wr_data,
	output logic fill_ack = 0, xlt_wr_ready = 0,
	output logic [31:0] fill_data = 0
);
	logic [31:0] mem[logic [31:0]];
	int w = 0;
	// fills wait for older writes, so a stale line is never read back
	always @(posedge clk) begin
		xlt_wr_ready <= nrst && !hold && $urandom % 3 != 0;
		if (xlt_wr_valid && xlt_wr_ready) mem[xlt_wr_addr] = xlt_wr_data;
		fill_ack <= 0;
		fill_data <= ~fill_data; // idle data line toggles
		if (fill_req && !fill_ack && !xlt_wr_valid && w++ > $urandom % 4) begin
			fill_ack <= 1;
			fill_data <= mem.exists(fill_addr) ? mem[fill_addr] : ~fill_addr;
			w = 0;
		end
	end
endmodule // vcwb_mem_model

// ### bench/tb_top.sv
// self-checking bench for the virtual cache
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, nrst = 0, cpu_req = 0, cpu_we = 0, hold = 0;
	logic [31:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata, fill_addr, fill_data;
	logic [31:0] xlt_wr_addr, xlt_wr_data, r;
	logic [2:0] cpu_fc = 0, fill_fc, xlt_wr_fc;
	logic cpu_ack, fill_req, fill_ack, xlt_wr_valid, xlt_wr_ready;
	int n_fail = 0, checked = 0, cyc = 0, lat;
	logic [31:0] ref_m[logic [31:0]];
	// expected posted writes: function code, address, data
	logic [66:0] wq[$], wx;
	always #20 clk = ~clk;
	vcwb_cache dut_u (.clk, .nrst, .cpu_req, .cpu_we, .cpu_addr, .cpu_fc,
		.cpu_wdata, .cpu_ack, .cpu_rdata, .fill_req, .fill_addr, .fill_fc,
		.fill_ack, .fill_data, .xlt_wr_valid, .xlt_wr_addr, .xlt_wr_fc,
		.xlt_wr_data, .xlt_wr_ready);
	vcwb_mem_model mem_u (.clk, .nrst, .hold, .fill_req, .xlt_wr_valid,
		.fill_addr, .xlt_wr_addr, .xlt_wr_data, .fill_ack, .xlt_wr_ready,
		.fill_data);
	task automatic test_done;
		if (n_fail == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, e);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("Error %0t got %h exp %h", $time, g, e);
		end
	endtask
	// one access, request held until the ack is seen
	task automatic acc(input logic we, input logic [31:0] a, d);
		logic [31:0] e;
		e = ref_m.exists(a) ? ref_m[a] : ~a;
		lat = 0;
		cpu_req = 1; cpu_we = we; cpu_addr = a; cpu_wdata = d;
		cpu_fc = 3'($urandom);
		do begin @(posedge clk); #1; lat++; end
		while (cpu_ack !== 1'b1 && lat < 300);
		chk({31'h0, cpu_ack}, 32'h1);
		cpu_req = 0;
		if (we) begin
			ref_m[a] = d;
			wq.push_back({cpu_fc, a, d});
		end else begin
			chk(cpu_rdata, e);
		end
		@(posedge clk); #1;
	endtask
	// hang guard
	always @(posedge clk) if (++cyc == 20000) begin
		n_fail++;
		test_done;
	end
	// posted writes leave in issue order with every field intact
	always @(negedge clk) if (nrst && xlt_wr_valid && xlt_wr_ready) begin
		wx = (wq.size() != 0) ? wq.pop_front()
			: ~{xlt_wr_fc, xlt_wr_addr, xlt_wr_data};
		chk(xlt_wr_addr, wx[63:32]);
		chk(xlt_wr_data, wx[31:0]);
		chk({29'h0, xlt_wr_fc}, {29'h0, wx[66:64]});
	end
	initial begin
		void'($urandom(32'h8557545f));
		repeat (16) @(posedge clk); #1;
		nrst = 1;
		hold = 1; // drain stalled: writes and hits go on
		for (int i = 0; i < 4; i++) acc(1, 32'h100 + 4 * i, $urandom);
		for (int i = 0; i < 4; i++) begin
			acc(0, 32'h100 + 4 * i, 0);
			chk(lat, 1);
		end
		// stage holds one write, buffer three: 0x200 fills it, 0x204 waits
		fork
			begin
				acc(1, 32'h200, $urandom);
				acc(1, 32'h204, $urandom);
			end
			begin repeat (12) @(posedge clk); #1 hold = 0; end
		join
		chk({31'h0, lat > 10}, 32'h1);
		// aliases differ only in high bits
		repeat (200) begin
			r = $urandom;
			acc(r[0], r & 32'h8010_100c, $urandom);
		end
		repeat (40) @(posedge clk);
		#1;
		foreach (ref_m[k]) chk(mem_u.mem[k], ref_m[k]);
		chk(wq.size(), 0);
		// reset in mid-run must clear the valid bit: a read of 0x100 must miss again
		nrst = 0;
		repeat (2) @(posedge clk);
		#1 nrst = 1;
		acc(0, 32'h100, 0);
		chk({31'h0, lat > 1}, 32'h1);
		test_done;
	end
endmodule // tb_top
